// file: rtl/serial_rate_generator_ctrl.sv
// Sample rate generator: bit clock divider, frame pulse and transmit frame sync
//
// Function
// R1: Resync off: bit clock runs free
// R2: Resync on: realign clock, frame after sync
// R3: Resync on: frame period field ignored
// R4: Resync and edge only with external clock
// R5: Edge select: 0 rising, 1 falling
// R6: Input select: 0 external pin, 1 CPU
// R7: Mode 0: tx sync on each copy
// R8: Mode 1: tx sync follows frame pulse
// R9: Frame period plus one bit clocks
// R10: Device reset: clock half CPU, frame low
// R11: Generator disabled: clock and frame low
// R12: Software resets generator only when unused
// R13: Software changes sections only in reset
// R14: Software waits two input clocks before enable
// R15: Software waits two bit clocks after enable
// R16: Enable: next input edge sets clock high
// R17: First frame eight bit clocks after enable
// R18: Divider plus one, odd divides high longer; divider 0 divides by two instead
// R19: Sync rising edge restarts clock high
// R20: Frame width plus one bit clocks
`timescale 1ns/10ps
`include "srg_map.svh"

module serial_rate_generator_ctrl (
   input  wire logic                   core_clk,
   input  wire logic                   nrst,
   input  wire logic [`SRG_ADDR_W-1:0] reg_addr,
   input  wire logic [`SRG_DATA_W-1:0] reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [`SRG_DATA_W-1:0] reg_rdata,
   input  wire logic                   external_clock_in,
   input  wire logic                   rx_frame_sync,
   input  wire logic                   tx_frame_direction,
   input  wire logic                   tx_copy_event,
   output logic                        generated_bit_clock,
   output logic                        generated_frame_pulse,
   output logic                        tx_frame_sync
);

   srg_pkg::ctrl2_s       ctrl2_reg;
   srg_pkg::ctrl1_s       ctrl1_reg;
   srg_pkg::status_s      status_now;
   srg_pkg::frame_state_e state_reg;
   srg_pkg::frame_state_e state_next;
   logic                  gen_en_reg;
   logic                  frame_en_reg;
   logic [1:0]            rst_hold_reg;
   logic                  div2_reg;
   logic                  ext_s1_reg;
   logic                  ext_s2_reg;
   logic                  ext_prev_reg;
   logic                  fs_s1_reg;
   logic                  fs_s2_reg;
   logic                  fs_prev_reg;
   logic                  fs_pend_reg;
   logic                  armed_reg;
   logic [7:0]            div_cnt_reg;
   logic [7:0]            div_cnt_next;
   logic                  bclk_next;
   logic [3:0]            start_cnt_reg;
   logic [3:0]            start_cnt_next;
   logic [11:0]           per_cnt_reg;
   logic [11:0]           per_cnt_next;
   logic [7:0]            wid_cnt_reg;
   logic [7:0]            wid_cnt_next;
   logic                  frame_next;
   logic                  in_reset;
   logic                  tick;
   logic                  resync_active;
   logic                  resync_fire;
   logic                  fs_rise;
   logic                  bclk_rise;

   function automatic logic rise_of(input logic now_v, input logic prev_v);
      rise_of = now_v & ~prev_v;
   endfunction
   // High phase gets the extra input cycle on odd divide ratios
   function automatic logic [7:0] high_len(input logic [7:0] div);
      high_len = {1'b0, div[7:1]} + 8'h01;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Reset hold and free-running half-rate clock
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_hold_reg <= `SRG_RST_HOLD_INIT;
      end else begin
         rst_hold_reg <= {rst_hold_reg[0], 1'b0};
      end
   end
   assign in_reset = rst_hold_reg[1];
   // No reset on purpose: it must toggle while reset is held
   always_ff @(posedge core_clk) begin
      if (div2_reg) begin
         div2_reg <= 1'b0;
      end else begin
         div2_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl2_reg    <= `SRG_CTRL2_RESET;
         ctrl1_reg    <= `SRG_CTRL1_RESET;
         gen_en_reg   <= 1'b0;
         frame_en_reg <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            `SRG_OFF_CTRL2: ctrl2_reg <= reg_wdata;
            `SRG_OFF_CTRL1: ctrl1_reg <= reg_wdata;
            `SRG_OFF_ENABLE: begin
               gen_en_reg   <= reg_wdata[`SRG_BIT_GEN_EN];
               frame_en_reg <= reg_wdata[`SRG_BIT_FRAME_EN];
            end
            default: ;
         endcase
      end
   end

   assign status_now = {12'h000, resync_active, (state_reg == srg_pkg::FR_RUN),
                        generated_frame_pulse, generated_bit_clock};
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            `SRG_OFF_CTRL2:  reg_rdata <= ctrl2_reg;
            `SRG_OFF_CTRL1:  reg_rdata <= ctrl1_reg;
            `SRG_OFF_ENABLE: reg_rdata <= {14'h0000, frame_en_reg, gen_en_reg};
            `SRG_OFF_STATUS: reg_rdata <= status_now;
            default:         reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and input clock tick
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ext_s1_reg   <= 1'b0;
         ext_s2_reg   <= 1'b0;
         ext_prev_reg <= 1'b0;
         fs_s1_reg    <= 1'b0;
         fs_s2_reg    <= 1'b0;
         fs_prev_reg  <= 1'b0;
      end else begin
         ext_s1_reg   <= external_clock_in;
         ext_s2_reg   <= ext_s1_reg;
         ext_prev_reg <= ext_s2_reg;
         fs_s1_reg    <= rx_frame_sync;
         fs_s2_reg    <= fs_s1_reg;
         fs_prev_reg  <= fs_s2_reg;
      end
   end

   // External clock is sampled, so it must stay well below half of core_clk
   assign tick = ctrl2_reg.input_clock_select    ? 1'b1 : // R6
                 ctrl2_reg.ext_clock_edge_select ? rise_of(ext_prev_reg, ext_s2_reg) // R5
                                                 : rise_of(ext_s2_reg, ext_prev_reg); // R5
   assign resync_active = ctrl2_reg.clock_resync_enable & ~ctrl2_reg.input_clock_select; // R4
   assign fs_rise       = rise_of(fs_s2_reg, fs_prev_reg); // R19
   assign resync_fire   = tick & fs_pend_reg & resync_active & gen_en_reg; // R2

   // Sync edge held until the input clock edge that serves it; a new edge wins over the clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fs_pend_reg <= 1'b0;
      end else if (!resync_active) begin
         fs_pend_reg <= 1'b0; // R1
      end else if (fs_rise) begin
         fs_pend_reg <= 1'b1;
      end else if (tick) begin
         fs_pend_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bit clock divider
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         armed_reg <= 1'b1;
      end else if (!gen_en_reg) begin
         armed_reg <= 1'b1;
      end else if (tick) begin
         armed_reg <= 1'b0;
      end
   end

   always_comb begin
      div_cnt_next = div_cnt_reg;
      bclk_next    = generated_bit_clock;
      if (in_reset) begin
         div_cnt_next = '0;
         bclk_next    = div2_reg; // R10
      end else if (!gen_en_reg) begin
         div_cnt_next = '0;
         bclk_next    = 1'b0; // R11
      end else if (tick) begin
         if (armed_reg || resync_fire) begin
            div_cnt_next = '0;
            bclk_next    = 1'b1; // R16 R19
         end else begin
            if (div_cnt_reg == ctrl1_reg.bit_clock_divider) begin
               div_cnt_next = '0;
            end else begin
               div_cnt_next = 8'(div_cnt_reg + 8'h01);
            end
            // Divide by one cannot be made from one tick; it toggles per tick
            if (ctrl1_reg.bit_clock_divider == 8'h00) begin
               bclk_next = ~generated_bit_clock;
            end else begin
               bclk_next = div_cnt_next < high_len(ctrl1_reg.bit_clock_divider); // R18
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         div_cnt_reg <= '0;
      end else begin
         div_cnt_reg <= div_cnt_next;
      end
   end
   // Kept free of the asynchronous reset so that it can divide during reset
   always_ff @(posedge core_clk) begin
      generated_bit_clock <= bclk_next;
   end
   assign bclk_rise = bclk_next & ~generated_bit_clock & gen_en_reg & ~in_reset;

   ////////////////////////////////////////////////////////////////////////////
   // Frame pulse
   always_comb begin
      state_next     = state_reg;
      start_cnt_next = start_cnt_reg;
      per_cnt_next   = per_cnt_reg;
      wid_cnt_next   = wid_cnt_reg;
      frame_next     = generated_frame_pulse;
      if (in_reset || !gen_en_reg || !frame_en_reg) begin
         state_next     = srg_pkg::FR_IDLE;
         start_cnt_next = '0;
         per_cnt_next   = '0;
         wid_cnt_next   = '0;
         frame_next     = 1'b0; // R10 R11
      end else begin
         if (generated_frame_pulse && bclk_rise) begin
            if (wid_cnt_reg == ctrl1_reg.frame_pulse_width) begin
               frame_next = 1'b0; // R20
            end else begin
               wid_cnt_next = 8'(wid_cnt_reg + 8'h01);
            end
         end
         case (state_reg)
            srg_pkg::FR_IDLE: begin
               state_next     = srg_pkg::FR_STARTUP;
               start_cnt_next = '0;
            end
            srg_pkg::FR_STARTUP: begin
               if (bclk_rise) begin
                  if (start_cnt_reg == `SRG_STARTUP_LAST) begin
                     state_next = srg_pkg::FR_RUN;
                     if (!resync_active) begin
                        frame_next   = 1'b1; // R17
                        wid_cnt_next = '0;
                        per_cnt_next = '0;
                     end
                  end else begin
                     start_cnt_next = 4'(start_cnt_reg + 4'h1);
                  end
               end
            end
            srg_pkg::FR_RUN: begin
               if (resync_active) begin
                  if (resync_fire) begin
                     frame_next   = 1'b1; // R2 R3
                     wid_cnt_next = '0;
                  end
               end else if (bclk_rise) begin
                  if (per_cnt_reg == ctrl2_reg.frame_period) begin
                     frame_next   = 1'b1; // R9
                     wid_cnt_next = '0;
                     per_cnt_next = '0;
                  end else begin
                     per_cnt_next = 12'(per_cnt_reg + 12'h001);
                  end
               end
            end
            default: state_next = srg_pkg::FR_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg             <= srg_pkg::FR_IDLE;
         start_cnt_reg         <= '0;
         per_cnt_reg           <= '0;
         wid_cnt_reg           <= '0;
         generated_frame_pulse <= 1'b0;
      end else begin
         state_reg             <= state_next;
         start_cnt_reg         <= start_cnt_next;
         per_cnt_reg           <= per_cnt_next;
         wid_cnt_reg           <= wid_cnt_next;
         generated_frame_pulse <= frame_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit frame sync
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tx_frame_sync <= 1'b0;
      end else if (!tx_frame_direction) begin
         tx_frame_sync <= 1'b0;
      end else if (ctrl2_reg.tx_frame_source_mode) begin
         tx_frame_sync <= frame_next; // R8
      end else begin
         tx_frame_sync <= tx_copy_event; // R7
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_RESET_FRAME_LOW: assert property (@(posedge core_clk) disable iff (!nrst) // R10
      in_reset |=> !generated_frame_pulse)
      else $error("frame pulse high during reset hold");
   AST_DISABLED_LOW: assert property (@(posedge core_clk) disable iff (!nrst) // R11
      (!gen_en_reg && !in_reset) |=> (!generated_bit_clock && !generated_frame_pulse))
      else $error("outputs not low while generator disabled");
   AST_FREE_RUN: assert property (@(posedge core_clk) disable iff (!nrst) // R1
      !ctrl2_reg.clock_resync_enable |-> !resync_fire)
      else $error("resync fired with resync disabled");
   AST_RESYNC_SOURCE: assert property (@(posedge core_clk) disable iff (!nrst) // R4
      ctrl2_reg.input_clock_select |-> !fs_pend_reg && !resync_fire)
      else $error("resync active with CPU clock source");
   AST_RESYNC_HIGH: assert property (@(posedge core_clk) disable iff (!nrst) // R19
      (resync_fire && !in_reset) |=> generated_bit_clock)
      else $error("bit clock not high after resync");
   AST_RESYNC_FRAME: assert property (@(posedge core_clk) disable iff (!nrst) // R2
      (resync_active && state_reg == srg_pkg::FR_RUN && !generated_frame_pulse && !resync_fire && frame_en_reg)
      |=> !generated_frame_pulse)
      else $error("frame started without sync in resync mode");
   AST_ENABLE_HIGH: assert property (@(posedge core_clk) disable iff (!nrst) // R16
      (armed_reg && gen_en_reg && tick && !in_reset) |=> generated_bit_clock)
      else $error("bit clock not high on first input edge");
   AST_STARTUP_QUIET: assert property (@(posedge core_clk) disable iff (!nrst) // R17
      (state_reg == srg_pkg::FR_STARTUP) |-> !generated_frame_pulse)
      else $error("frame pulse during startup wait");
   AST_FIRST_FRAME: assert property (@(posedge core_clk) disable iff (!nrst) // R17
      $rose(generated_frame_pulse) && $past(state_reg) == srg_pkg::FR_STARTUP
      |-> $past(start_cnt_reg) == `SRG_STARTUP_LAST)
      else $error("first frame not after eight bit clocks");
   AST_TX_COPY: assert property (@(posedge core_clk) disable iff (!nrst) // R7
      (tx_frame_direction && !ctrl2_reg.tx_frame_source_mode) |=> (tx_frame_sync == $past(tx_copy_event)))
      else $error("tx sync does not follow copy event");
   AST_TX_FOLLOW: assert property (@(posedge core_clk) disable iff (!nrst) // R8
      (tx_frame_direction && ctrl2_reg.tx_frame_source_mode) |=> (tx_frame_sync == generated_frame_pulse))
      else $error("tx sync does not follow frame pulse");

endmodule

// file: shared/srg_map.svh
// Register map, field positions, reset values and counts of the rate generator
`ifndef SRG_MAP_SVH
`define SRG_MAP_SVH
`define SRG_ADDR_W          2
`define SRG_DATA_W          16
`define SRG_OFF_CTRL2       2'h0
`define SRG_OFF_CTRL1       2'h1
`define SRG_OFF_ENABLE      2'h2
`define SRG_OFF_STATUS      2'h3
`define SRG_BIT_RESYNC      15
`define SRG_BIT_EDGE        14
`define SRG_BIT_CLKSEL      13
`define SRG_BIT_FMODE       12
`define SRG_BIT_GEN_EN      0
`define SRG_BIT_FRAME_EN    1
`define SRG_CTRL2_RESET     16'h2000
`define SRG_CTRL1_RESET     16'h0001
`define SRG_STARTUP_BCLKS   4'h8
`define SRG_STARTUP_LAST    4'h7
`define SRG_RST_HOLD_INIT   2'h3
`endif

// file: shared/srg_pkg.sv
// Types shared by the rate generator design
package srg_pkg;
   typedef struct packed {
      logic        clock_resync_enable;
      logic        ext_clock_edge_select;
      logic        input_clock_select;
      logic        tx_frame_source_mode;
      logic [11:0] frame_period;
   } ctrl2_s;
   typedef struct packed {
      logic [7:0] frame_pulse_width;
      logic [7:0] bit_clock_divider;
   } ctrl1_s;
   typedef struct packed {
      logic [11:0] zero;
      logic        resync_active;
      logic        frame_running;
      logic        frame_pulse;
      logic        bit_clock;
   } status_s;
   typedef enum logic [2:0] {
      FR_IDLE    = 3'h1,
      FR_STARTUP = 3'h2,
      FR_RUN     = 3'h4
   } frame_state_e;
endpackage

// file: dv/ext_source_model.sv
// Model of the external source clock pin and the receive frame sync pin
`timescale 1ns/10ps

module ext_source_model #(
   parameter int HALF = 8
) (
   input  wire logic core_clk,
   input  wire logic run,
   input  wire logic sync_req,
   output logic      ext_clk,
   output logic      frame_sync
);
   int   phase;
   int   hold;
   logic pending;

   initial begin
      ext_clk = 1'b0;
      frame_sync = 1'b0;
      phase = 0;
      hold = 0;
      pending = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source clock runs free once started, as a crystal would
   always @(posedge core_clk) begin
      if (run) begin
         if (phase == HALF - 1) begin
            phase <= 0;
            ext_clk <= ~ext_clk;
         end else begin
            phase <= phase + 1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sync launched at a clock fall, so the next rising edge sees it settled
   always @(posedge core_clk) begin
      if (sync_req) begin
         pending <= 1'b1;
      end
      if (pending && ext_clk && phase == HALF - 1) begin
         frame_sync <= 1'b1;
         hold <= 4 * HALF;
         pending <= 1'b0;
      end else if (hold > 0) begin
         hold <= hold - 1;
         if (hold == 1) begin
            frame_sync <= 1'b0;
         end
      end
   end
endmodule

// file: dv/tb_top.sv
// Self-checking bench of the sample rate generator
`timescale 1ns/10ps
`include "srg_map.svh"
`define CHK(nm, ex, got) begin check_count++; if ((ex) !== (got)) begin errors++; \
   $display("BAD %s expected %0h seen %0h", nm, ex, got); end end

module tb_top;
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [1:0]  reg_addr = 2'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic        external_clock_in, rx_frame_sync;
   logic        tx_frame_direction = 1'b0;
   logic        tx_copy_event = 1'b0;
   logic        generated_bit_clock, generated_frame_pulse, tx_frame_sync;
   logic        run_ext = 1'b0;
   logic        sync_req = 1'b0;
   logic        ext_mode = 1'b0;
   logic        edge_exp = 1'b0;
   logic        rd_seen = 1'b0;
   logic        pc, pf, cr, fr, ff, pm;
   logic [15:0] exp_q[$];
   logic [15:0] exp_v;
   int          errors = 0;
   int          check_count = 0;
   int          cycles = 0;
   int          n, m, h;
   logic [31:0] v;

   always #50 core_clk = ~core_clk;

   serial_rate_generator_ctrl dut (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .external_clock_in, .rx_frame_sync, .tx_frame_direction, .tx_copy_event,
      .generated_bit_clock, .generated_frame_pulse, .tx_frame_sync);

   ext_source_model #(.HALF(8)) src (.core_clk(core_clk), .run(run_ext), .sync_req(sync_req),
      .ext_clk(external_clock_in), .frame_sync(rx_frame_sync));

   ////////////////////////////////////////////////////////////////////////////
   // Read data stand one cycle only, so compare exactly then
   always @(posedge core_clk) begin
      if (rd_seen) begin
         exp_v = exp_q.pop_front();
         `CHK("reg_rdata", exp_v, reg_rdata)
      end
      rd_seen <= reg_rd;
      if (ext_mode && generated_bit_clock === 1'b1 && pm === 1'b0)
         `CHK("source pin at bit clock rise", ~edge_exp, external_clock_in)
      pm <= generated_bit_clock;
      cycles++;
      if (cycles == 60000) begin
         errors++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [1:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask

   task tick();
      pc = generated_bit_clock;
      pf = generated_frame_pulse;
      @(posedge core_clk);
      cr = generated_bit_clock & ~pc;
      fr = generated_frame_pulse & ~pf;
      ff = ~generated_frame_pulse & pf;
   endtask

   // Counts bit clock rises until the frame pulse rises or falls
   task automatic rises_until(input bit on_fall, output int k);
      k = 0;
      for (int i = 0; i < 3000; i++) begin
         tick();
         if (cr) k++;
         if (on_fall ? ff : fr) break;
      end
   endtask

   task automatic count_lvl(input logic l, output int k);
      k = 0;
      while (generated_bit_clock === l && k < 3000) begin
         k++;
         @(posedge core_clk);
      end
   endtask

   task automatic clk_shape(input int hi, input int lo);
      int k;
      count_lvl(1'b1, k);
      count_lvl(1'b0, k);
      count_lvl(1'b1, k);
      `CHK("bit clock high", hi, k)
      count_lvl(1'b0, k);
      `CHK("bit clock low", lo, k)
   endtask

   task report_and_stop();
      if (errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      v = $urandom(32'h92791EBF);
      // Bit clock is unknown until the second edge in reset
      repeat (3) @(posedge core_clk);
      repeat (3) begin
         pc = generated_bit_clock;
         @(posedge core_clk);
         `CHK("bit clock toggles in reset", ~pc, generated_bit_clock)
         `CHK("frame in reset", 1'b0, generated_frame_pulse)
      end
      nrst <= 1'b1;
      @(posedge core_clk);
      rd(`SRG_OFF_CTRL2, `SRG_CTRL2_RESET);
      rd(`SRG_OFF_CTRL1, `SRG_CTRL1_RESET);
      rd(`SRG_OFF_ENABLE, 16'h0000);
      `CHK("bit clock while disabled", 1'b0, generated_bit_clock)
      repeat (4) begin
         v = $urandom();
         wr(`SRG_OFF_CTRL2, v[15:0]);
         wr(`SRG_OFF_CTRL1, v[31:16]);
         rd(`SRG_OFF_CTRL2, v[15:0]);
         rd(`SRG_OFF_CTRL1, v[31:16]);
      end
      wr(`SRG_OFF_STATUS, 16'hFFFF);
      rd(`SRG_OFF_STATUS, {12'h000, v[15] & ~v[13], 3'h0});
      // CPU source, divider sweep across odd, even and zero
      wr(`SRG_OFF_CTRL2, 16'h2000);
      for (int d = 0; d < 5; d++) begin
         wr(`SRG_OFF_CTRL1, 16'(d));
         repeat (3) @(posedge core_clk);
         wr(`SRG_OFF_ENABLE, 16'h0001);
         count_lvl(1'b0, n);
         `CHK("bit clock rises at once", 1'b1, n <= 3)
         clk_shape(d == 0 ? 1 : d / 2 + 1, d == 0 ? 1 : d - d / 2);
         wr(`SRG_OFF_ENABLE, 16'h0000);
         @(posedge core_clk);
         `CHK("bit clock after disable", 1'b0, generated_bit_clock)
      end
      // Frames from CPU source; resync bit set but has no effect here
      wr(`SRG_OFF_CTRL1, 16'h0101);
      wr(`SRG_OFF_CTRL2, 16'hB003);
      tx_frame_direction <= 1'b1;
      repeat (3) @(posedge core_clk);
      wr(`SRG_OFF_ENABLE, 16'h0001);
      repeat (8) @(posedge core_clk);
      wr(`SRG_OFF_ENABLE, 16'h0003);
      // Startup count begins one edge after the frame enable lands
      @(posedge core_clk);
      rises_until(1'b0, n);
      `CHK("bit clocks to first frame", 8, n)
      tick();
      `CHK("tx sync follows frame", 1'b1, tx_frame_sync)
      rises_until(1'b1, n);
      `CHK("frame width", 2, n)
      rises_until(1'b0, m);
      `CHK("frame period", 4, n + m)
      wr(`SRG_OFF_CTRL2, 16'hA003);
      tx_copy_event <= 1'b1;
      @(posedge core_clk);
      tx_copy_event <= 1'b0;
      @(posedge core_clk);
      `CHK("tx sync on copy", 1'b1, tx_frame_sync)
      h = 0;
      repeat (40) begin
         @(posedge core_clk);
         h += int'(tx_frame_sync === 1'b1);
      end
      `CHK("tx sync without copy", 0, h)
      wr(`SRG_OFF_ENABLE, 16'h0000);
      @(posedge core_clk);
      `CHK("frame after disable", 1'b0, generated_frame_pulse)
      // External source, falling edge, free running
      wr(`SRG_OFF_CTRL2, 16'h4000);
      wr(`SRG_OFF_CTRL1, 16'h0001);
      run_ext <= 1'b1;
      edge_exp <= 1'b1;
      ext_mode <= 1'b1;
      repeat (40) @(posedge core_clk);
      wr(`SRG_OFF_ENABLE, 16'h0001);
      clk_shape(16, 16);
      wr(`SRG_OFF_ENABLE, 16'h0000);
      // External source, rising edge, resync on frame sync
      wr(`SRG_OFF_CTRL2, 16'h8003);
      wr(`SRG_OFF_CTRL1, 16'h0003);
      edge_exp <= 1'b0;
      repeat (40) @(posedge core_clk);
      wr(`SRG_OFF_ENABLE, 16'h0003);
      h = 0;
      repeat (1200) begin
         tick();
         h += int'(fr);
      end
      `CHK("frames without sync", 0, h)
      repeat (2) begin
         sync_req <= 1'b1;
         @(posedge core_clk);
         sync_req <= 1'b0;
         rises_until(1'b0, n);
         `CHK("frame soon after sync", 1'b1, n <= 2)
         `CHK("bit clock high after resync", 1'b1, generated_bit_clock)
         repeat (300) @(posedge core_clk);
      end
      report_and_stop();
   end
endmodule
